// ==== gamc_pkg.sv ====
// constants, register map and mode codes of the gas alarm mode controller
// assumes a 250 MHz pclk and a 32-bit APB register bus
package gamc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam longint HALF_SEC_NS = 500000000;
  localparam longint KEY_HOLD_NS = 2000000000;
  localparam int HALF_CYC_DEF = int'(HALF_SEC_NS / CLK_PERIOD_NS);
  localparam int HOLD_CYC_DEF = int'((KEY_HOLD_NS + CLK_PERIOD_NS - 1) /
                                     CLK_PERIOD_NS);
  // durations counted in half seconds
  localparam logic [11:0] BANNER_HALVES = 12'h001;
  localparam logic [11:0] VERSION_HALVES = 12'h001;
  localparam logic [11:0] WARM_HALVES = 12'h03C;
  localparam logic [11:0] TIMEOUT_HALVES = 12'hE10;
  // ==========================================================
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TH1 = 8'h04;
  localparam logic [7:0] OFF_TH2 = 8'h08;
  localparam logic [7:0] OFF_TH3 = 8'h0C;
  localparam logic [7:0] OFF_DWELL = 8'h10;
  localparam logic [7:0] OFF_HSCALE = 8'h14;
  localparam logic [7:0] OFF_TESTVAL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_VALUE = 8'h20;
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_AUTO_TO = 1;
  localparam int DWELL_W = 6;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] HSCALE_RST = 16'h0064;
  localparam logic [15:0] TH1_RST = 16'h0014;
  localparam logic [15:0] TH2_RST = 16'h0028;
  localparam logic [15:0] TH3_RST = 16'h0032;
  // ==========================================================
  // modes and display selections
  typedef enum logic [6:0] {
    GAMC_BANNER = 7'h01,
    GAMC_VERSION = 7'h02,
    GAMC_WARM = 7'h04,
    GAMC_MEAS = 7'h08,
    GAMC_TEST = 7'h10,
    GAMC_LAMP = 7'h20,
    GAMC_SBY = 7'h40
  } gamc_mode_t;
  localparam logic [2:0] DSP_BANNER = 3'h0;
  localparam logic [2:0] DSP_VERSION = 3'h1;
  localparam logic [2:0] DSP_WARM = 3'h2;
  localparam logic [2:0] DSP_CONC = 3'h3;
  localparam logic [2:0] DSP_UNDER = 3'h4;
  localparam logic [2:0] DSP_OVER = 3'h5;
  localparam logic [2:0] DSP_LAMP = 3'h6;
endpackage : gamc_pkg

// ==== gamc_ctrl.sv ====
// gas alarm mode controller: start-up, measurement, alarms, test, stand-by
// assumes synchronous key inputs (high = pressed) and an APB master
// Overview of operation
// - show version banner half a second, then version number.
// - flash warm-up banner thirty seconds, then enter measurement.
// - unit or detector fault at warm-up end raises fault alarm.
// - no detector or input below -10% scale flashes under-range.
// - under-range lights trouble lamp, flashes warning light, sounds buzzer.
// - silence key stops buzzer, warning light goes steady.
// - input above scale plus 10% flashes excess-range indication.
// - excess-range flashes all alarm lamps and warning light, buzzer.
// - alarm asserts only after dwell time above threshold.
// - alarm relay energises only after dwell time exceeded.
// - latching holds alarm and peak value until reset.
// - without latching each alarm clears when below threshold.
// - external reset contact clears alarms as the reset key does.
// - three alarm relays and one trouble relay.
// - test key held two seconds in measurement enters test mode.
// - test mode returns after thirty minutes without key.
// - test mode uses adjusted value, flashes it, alarms run normally.
// - in test, function held starts lamp test; reset returns.
// - down key held two seconds in measurement enters stand-by.
// - auto-timeout on leaves stand-by after thirty minutes.
// - auto-timeout off leaves stand-by on down held two seconds.
// - stand-by flashes its lamp and holds all relays inactive.
module gamc_ctrl #(
  parameter int HALF_CYC = gamc_pkg::HALF_CYC_DEF,
  parameter int HOLD_CYC = gamc_pkg::HOLD_CYC_DEF,
  // arbitrary version code
  parameter logic [15:0] VERSION_CODE = 16'h0100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] conc,
  input wire logic detector_present,
  input wire logic unit_fault,
  input wire logic test_key,
  input wire logic function_key,
  input wire logic down_key,
  input wire logic reset_key,
  input wire logic buzzer_silence_key,
  input wire logic ext_reset_short,
  output logic [2:0] segment_display_sel,
  output logic [15:0] segment_display_value,
  output logic segment_display_flash,
  output logic [2:0] alarm_lamp,
  output logic trouble_lamp,
  output logic warning_light,
  output logic buzzer,
  output logic standby_lamp,
  output logic [2:0] alarm_relay,
  output logic trouble_relay
);
  // ==========================================================
  // state
  typedef struct packed {
    gamc_pkg::gamc_mode_t mode;
    logic [11:0] mcnt;
    logic [31:0] hcnt;
    logic [31:0] kcnt;
    logic kdone;
    logic flash;
    logic silenced;
    logic fault_alarm;
    logic [2:0] alarm;
    logic [2:0][7:0] dcnt;
    logic [15:0] peak;
    logic [1:0] ctrl;
    logic [2:0][15:0] th;
    logic [2:0][gamc_pkg::DWELL_W-1:0] dwell;
    logic [15:0] hscale;
    logic [15:0] testval;
    logic [31:0] rdata;
    logic [2:0] dsel;
    logic [15:0] dval;
    logic dflash;
    logic [2:0] alamp;
    logic tlamp;
    logic warn;
    logic buzz;
    logic slamp;
    logic [2:0] relay;
    logic trelay;
  } gamc_state_t;

  gamc_state_t st;
  gamc_state_t next_st;
  logic tick;
  logic hold_evt;
  logic any_key;
  logic rst_evt;
  logic active;
  logic under;
  logic over;
  logic latch;
  logic mode_end;
  logic timeout;
  logic hit;
  logic signed [17:0] eff;
  logic signed [17:0] margin;
  logic [2:0] above;
  logic [15:0] shown;

  // ==========================================================
  // combinational next state
  always_comb begin
    next_st = st;
    tick = (st.hcnt == 32'(HALF_CYC - 1));
    any_key = test_key | function_key | down_key | reset_key |
              buzzer_silence_key;
    rst_evt = reset_key | ext_reset_short;
    latch = st.ctrl[gamc_pkg::CTRL_LATCH];
    active = (st.mode != gamc_pkg::GAMC_BANNER) &&
             (st.mode != gamc_pkg::GAMC_VERSION) &&
             (st.mode != gamc_pkg::GAMC_WARM);
    mode_end = 1'b0;
    timeout = tick && (st.mcnt == gamc_pkg::TIMEOUT_HALVES - 12'h001);
    // half-second base and one-second flash period
    next_st.hcnt = tick ? 32'h0 : st.hcnt + 32'h1;
    if (tick) begin
      next_st.flash = ~st.flash;
    end
    // key hold timer, fires once per press
    hold_evt = 1'b0;
    if (!(test_key | function_key | down_key)) begin
      next_st.kcnt = 32'h0;
      next_st.kdone = 1'b0;
    end else if (!st.kdone) begin
      if (st.kcnt == 32'(HOLD_CYC - 1)) begin
        hold_evt = 1'b1;
        next_st.kdone = 1'b1;
      end else begin
        next_st.kcnt = st.kcnt + 32'h1;
      end
    end
    // range checks on the live input
    margin = 18'(st.hscale / 16'h000A);
    under = !detector_present || (18'(conc) < -margin);
    over = detector_present &&
           (18'(conc) > $signed(18'(st.hscale)) + margin);
    // test mode replaces the measured value
    if (st.mode == gamc_pkg::GAMC_TEST || st.mode == gamc_pkg::GAMC_LAMP) begin
      eff = 18'($signed(st.testval));
    end else begin
      eff = 18'(conc);
    end
    // ========================================================
    // mode sequencing
    next_st.mcnt = tick ? st.mcnt + 12'h001 : st.mcnt;
    unique case (st.mode)
      gamc_pkg::GAMC_BANNER: begin
        if (tick && st.mcnt == gamc_pkg::BANNER_HALVES - 12'h001) begin
          next_st.mode = gamc_pkg::GAMC_VERSION;
          mode_end = 1'b1;
        end
      end
      gamc_pkg::GAMC_VERSION: begin
        if (tick && st.mcnt == gamc_pkg::VERSION_HALVES - 12'h001) begin
          next_st.mode = gamc_pkg::GAMC_WARM;
          mode_end = 1'b1;
        end
      end
      gamc_pkg::GAMC_WARM: begin
        if (tick && st.mcnt == gamc_pkg::WARM_HALVES - 12'h001) begin
          next_st.mode = gamc_pkg::GAMC_MEAS;
          mode_end = 1'b1;
          if (unit_fault || under) begin
            next_st.fault_alarm = 1'b1;
          end
        end
      end
      gamc_pkg::GAMC_MEAS: begin
        if (hold_evt && test_key) begin
          next_st.mode = gamc_pkg::GAMC_TEST;
          mode_end = 1'b1;
        end else if (hold_evt && down_key) begin
          next_st.mode = gamc_pkg::GAMC_SBY;
          mode_end = 1'b1;
        end
      end
      gamc_pkg::GAMC_TEST, gamc_pkg::GAMC_LAMP: begin
        if (reset_key || timeout) begin
          next_st.mode = gamc_pkg::GAMC_MEAS;
          mode_end = 1'b1;
        end else if (hold_evt && function_key) begin
          next_st.mode = gamc_pkg::GAMC_LAMP;
          mode_end = 1'b1;
        end else if (any_key) begin
          mode_end = 1'b1;
        end
      end
      gamc_pkg::GAMC_SBY: begin
        if ((st.ctrl[gamc_pkg::CTRL_AUTO_TO] && timeout) ||
            (hold_evt && down_key)) begin
          next_st.mode = gamc_pkg::GAMC_MEAS;
          mode_end = 1'b1;
        end
      end
    endcase
    if (mode_end) begin
      next_st.mcnt = 12'h000;
    end
    // ========================================================
    // alarm channels
    for (int i = 0; i < 3; i++) begin
      above[i] = active && (eff >= $signed(18'(st.th[i])));
      if (!above[i] || rst_evt) begin
        next_st.dcnt[i] = 8'h00;
      end else if (tick && st.dcnt[i] != 8'hFF) begin
        next_st.dcnt[i] = st.dcnt[i] + 8'h01;
      end
      if (rst_evt) begin
        next_st.alarm[i] = 1'b0;
      end else if (above[i] &&
                   st.dcnt[i] > {1'b0, st.dwell[i], 1'b0}) begin
        next_st.alarm[i] = 1'b1;
      end else if (!latch && !above[i]) begin
        next_st.alarm[i] = 1'b0;
      end
    end
    if (rst_evt) begin
      next_st.fault_alarm = 1'b0;
    end
    // latched alarms keep the peak value on show
    if (latch && (|st.alarm) && !rst_evt) begin
      if (eff > 18'($signed(st.peak))) begin
        next_st.peak = eff[15:0];
      end
    end else begin
      next_st.peak = eff[15:0];
    end
    shown = (latch && (|st.alarm)) ? st.peak : eff[15:0];
    // silence holds until the fault conditions go away
    if (!(under || over || st.fault_alarm || (|st.alarm))) begin
      next_st.silenced = 1'b0;
    end else if (buzzer_silence_key) begin
      next_st.silenced = 1'b1;
    end
    // ========================================================
    // indicators and relays
    next_st.dval = shown;
    next_st.dflash = 1'b0;
    next_st.dsel = gamc_pkg::DSP_CONC;
    next_st.alamp = st.alarm;
    next_st.tlamp = st.fault_alarm;
    next_st.warn = (|st.alarm) || st.fault_alarm;
    next_st.buzz = ((|st.alarm) || st.fault_alarm) && !st.silenced;
    next_st.slamp = 1'b0;
    if (st.mode == gamc_pkg::GAMC_BANNER) begin
      next_st.dsel = gamc_pkg::DSP_BANNER;
    end else if (st.mode == gamc_pkg::GAMC_VERSION) begin
      next_st.dsel = gamc_pkg::DSP_VERSION;
      next_st.dval = VERSION_CODE;
    end else if (st.mode == gamc_pkg::GAMC_WARM) begin
      next_st.dsel = gamc_pkg::DSP_WARM;
      next_st.dflash = st.flash;
    end else if (st.mode == gamc_pkg::GAMC_LAMP) begin
      next_st.dsel = gamc_pkg::DSP_LAMP;
      next_st.alamp = 3'h7;
      next_st.tlamp = 1'b1;
      next_st.warn = 1'b1;
      next_st.slamp = 1'b1;
    end else if (under) begin
      next_st.dsel = gamc_pkg::DSP_UNDER;
      next_st.dflash = st.flash;
      next_st.tlamp = 1'b1;
      next_st.warn = st.silenced | st.flash;
      next_st.buzz = !st.silenced;
    end else if (over) begin
      next_st.dsel = gamc_pkg::DSP_OVER;
      next_st.dflash = st.flash;
      next_st.alamp = {3{st.flash}};
      next_st.warn = st.silenced | st.flash;
      next_st.buzz = !st.silenced;
    end else if (st.mode == gamc_pkg::GAMC_TEST) begin
      next_st.dflash = st.flash;
    end
    if (st.mode == gamc_pkg::GAMC_SBY) begin
      next_st.slamp = st.flash;
      next_st.relay = 3'h0;
      next_st.trelay = 1'b0;
    end else begin
      next_st.relay = st.alarm;
      next_st.trelay = st.fault_alarm || (active && under);
    end
    // ========================================================
    // APB slave, zero wait states
    hit = (paddr[1:0] == 2'h0) && (paddr <= gamc_pkg::OFF_VALUE);
    if (psel && !penable) begin
      unique case (paddr)
        gamc_pkg::OFF_CTRL: next_st.rdata = {30'h0, st.ctrl};
        gamc_pkg::OFF_TH1: next_st.rdata = {16'h0, st.th[0]};
        gamc_pkg::OFF_TH2: next_st.rdata = {16'h0, st.th[1]};
        gamc_pkg::OFF_TH3: next_st.rdata = {16'h0, st.th[2]};
        gamc_pkg::OFF_DWELL: next_st.rdata = {14'h0, st.dwell};
        gamc_pkg::OFF_HSCALE: next_st.rdata = {16'h0, st.hscale};
        gamc_pkg::OFF_TESTVAL: next_st.rdata = {16'h0, st.testval};
        gamc_pkg::OFF_STATUS: next_st.rdata = {18'h0, st.mode, st.silenced,
                                               st.fault_alarm, over, under,
                                               st.alarm};
        gamc_pkg::OFF_VALUE: next_st.rdata = {16'h0, shown};
        default: next_st.rdata = 32'h0;
      endcase
    end
    if (psel && penable && pwrite) begin
      unique case (paddr)
        gamc_pkg::OFF_CTRL: next_st.ctrl = pwdata[1:0];
        gamc_pkg::OFF_TH1: next_st.th[0] = pwdata[15:0];
        gamc_pkg::OFF_TH2: next_st.th[1] = pwdata[15:0];
        gamc_pkg::OFF_TH3: next_st.th[2] = pwdata[15:0];
        gamc_pkg::OFF_DWELL: next_st.dwell = pwdata[3*gamc_pkg::DWELL_W-1:0];
        gamc_pkg::OFF_HSCALE: next_st.hscale = pwdata[15:0];
        gamc_pkg::OFF_TESTVAL: next_st.testval = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mode <= gamc_pkg::GAMC_BANNER;
      st.ctrl <= gamc_pkg::CTRL_RST;
      st.th <= {gamc_pkg::TH3_RST, gamc_pkg::TH2_RST, gamc_pkg::TH1_RST};
      st.hscale <= gamc_pkg::HSCALE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = st.rdata;
  assign segment_display_sel = st.dsel;
  assign segment_display_value = st.dval;
  assign segment_display_flash = st.dflash;
  assign alarm_lamp = st.alamp;
  assign trouble_lamp = st.tlamp;
  assign warning_light = st.warn;
  assign buzzer = st.buzz;
  assign standby_lamp = st.slamp;
  assign alarm_relay = st.relay;
  assign trouble_relay = st.trelay;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_banner_then_version: assert property (
    st.mode == gamc_pkg::GAMC_BANNER && next_st.mode != st.mode
    |=> st.mode == gamc_pkg::GAMC_VERSION)
    else $error("banner not followed by version");
  a_warm_to_meas: assert property (
    st.mode == gamc_pkg::GAMC_WARM && tick &&
    st.mcnt == gamc_pkg::WARM_HALVES - 12'h001
    |=> st.mode == gamc_pkg::GAMC_MEAS)
    else $error("warm-up did not end in measurement");
  a_fault_at_end: assert property (
    st.mode == gamc_pkg::GAMC_WARM && next_st.mode == gamc_pkg::GAMC_MEAS &&
    unit_fault && !rst_evt |=> st.fault_alarm)
    else $error("fault at warm-up end not raised");
  a_under_lamps: assert property (
    active && under && st.mode != gamc_pkg::GAMC_LAMP && !st.silenced
    |=> trouble_lamp && buzzer)
    else $error("under-range indication missing");
  a_silence_stops: assert property (
    active && (under || over) && buzzer_silence_key ##1 (under || over)
    |=> !buzzer && (warning_light || st.mode == gamc_pkg::GAMC_SBY))
    else $error("silence key did not stop buzzer");
  a_relay_after_alarm: assert property (
    $rose(alarm_relay[0]) |-> $past(st.alarm[0]))
    else $error("relay energised without alarm");
  a_latch_holds: assert property (
    latch && st.alarm[1] && !rst_evt |=> st.alarm[1])
    else $error("latched alarm released without reset");
  a_auto_clear: assert property (
    !latch && st.alarm[2] && !above[2] && !rst_evt |=> !st.alarm[2])
    else $error("unlatched alarm not cleared");
  a_ext_reset: assert property (
    ext_reset_short |=> st.alarm == 3'h0 && !st.fault_alarm)
    else $error("external reset did not clear alarms");
  a_test_timeout: assert property (
    st.mode == gamc_pkg::GAMC_TEST && timeout && !any_key
    |=> st.mode == gamc_pkg::GAMC_MEAS)
    else $error("test mode did not time out");
  a_standby_timeout: assert property (
    st.mode == gamc_pkg::GAMC_SBY && st.ctrl[gamc_pkg::CTRL_AUTO_TO] &&
    timeout |=> st.mode == gamc_pkg::GAMC_MEAS)
    else $error("stand-by did not time out");
  a_standby_relays: assert property (
    st.mode == gamc_pkg::GAMC_SBY ##1 st.mode == gamc_pkg::GAMC_SBY
    |-> alarm_relay == 3'h0 && !trouble_relay)
    else $error("relay active in stand-by");

  c_alarm_set: cover property ($rose(st.alarm[0]));
  c_test_mode: cover property ($rose(st.mode == gamc_pkg::GAMC_TEST));
  c_standby: cover property ($rose(st.mode == gamc_pkg::GAMC_SBY));
  c_lamp_test: cover property ($rose(st.mode == gamc_pkg::GAMC_LAMP));
endmodule : gamc_ctrl

// ==== gamc_field.sv ====
// far-side model: current-loop detector and front-panel key switches
// assumes the bench sets the commands just after a rising pclk edge
// ==========================================================
// detector and keys
module gamc_field (
  input wire logic pclk,
  input wire logic signed [15:0] cmd_conc,
  input wire logic cmd_present,
  input wire logic cmd_fault,
  input wire logic [5:0] cmd_keys,
  output logic signed [15:0] conc,
  output logic detector_present,
  output logic unit_fault,
  output logic [5:0] keys
);
  initial begin
    conc = 16'sh0000;
    detector_present = 1'b1;
    unit_fault = 1'b0;
    keys = 6'h00;
  end
  always @(posedge pclk) begin
    // an open loop carries no value: the reading wanders
    conc <= cmd_present ? cmd_conc : ~conc;
    detector_present <= cmd_present;
    unit_fault <= cmd_fault;
    keys <= cmd_keys;
  end
endmodule : gamc_field

// ==== gas_alarm_mode_controller_bench.sv ====
// self-checking bench of the gas alarm mode controller
// assumes gamc_pkg, gamc_ctrl and gamc_field are compiled before it
module gas_alarm_mode_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VERSION_ID = 16'h0100; // arbitrary version code
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [15:0] cmd_conc;
  logic cmd_present;
  logic cmd_fault;
  logic [5:0] cmd_keys;
  logic signed [15:0] conc;
  logic present;
  logic fault;
  logic [5:0] keys;
  logic [2:0] sel;
  logic [15:0] value;
  logic flash;
  logic [2:0] lamps;
  logic trbl;
  logic warn;
  logic buzz;
  logic sby;
  logic [2:0] relay;
  logic trelay;
  int errors;
  int n_checks;
  int waited;
  logic [31:0] d;
  logic e;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h24};
  logic [31:0] rv [6] = '{32'h1, 32'h14, 32'h28, 32'h32, 32'h64, 32'h0};
  logic [15:0] cv [6] = '{16'hFFF6, 16'hFFF5, 16'h0000, 16'h006E,
                          16'h006F, 16'h0000};
  logic [2:0] cs [6] = '{3'h3, 3'h4, 3'h3, 3'h3, 3'h5, 3'h3};
  // ==========================================================
  // design and far side
  gamc_field field (.pclk(pclk), .cmd_conc(cmd_conc),
    .cmd_present(cmd_present), .cmd_fault(cmd_fault), .cmd_keys(cmd_keys),
    .conc(conc), .detector_present(present), .unit_fault(fault),
    .keys(keys));
  gamc_ctrl #(.HALF_CYC(20), .HOLD_CYC(8), .VERSION_CODE(VERSION_ID)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conc(conc),
    .detector_present(present), .unit_fault(fault), .test_key(keys[0]),
    .function_key(keys[1]), .down_key(keys[2]), .reset_key(keys[3]),
    .buzzer_silence_key(keys[4]), .ext_reset_short(keys[5]),
    .segment_display_sel(sel), .segment_display_value(value),
    .segment_display_flash(flash), .alarm_lamp(lamps), .trouble_lamp(trbl),
    .warning_light(warn), .buzzer(buzz), .standby_lamp(sby),
    .alarm_relay(relay), .trouble_relay(trelay));
  always #2 pclk = ~pclk;
  // ==========================================================
  // tasks
  function automatic logic [31:0] probe(input string nm);
    case (nm)
      "sel": return 32'(sel);
      "relay": return 32'(relay);
      "trelay": return 32'(trelay);
      "buzz": return 32'(buzz);
      "trbl": return 32'(trbl);
      "warn": return 32'(warn);
      "lamps": return 32'(lamps);
      "flash": return 32'(flash);
      default: return 32'(sby);
    endcase
  endfunction : probe
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_sig(input string nm, input logic [31:0] exp,
                          input int lim);
    waited = 0;
    do begin
      @(negedge pclk);
      waited++;
    end while (probe(nm) !== exp && waited < lim);
    chk(nm, exp, probe(nm));
  endtask : wait_sig
  task automatic stay(input string nm, input logic [31:0] exp,
                      input int lim);
    logic [31:0] bad;
    bad = exp;
    repeat (lim) begin
      @(negedge pclk);
      if (probe(nm) !== exp) bad = probe(nm);
    end
    chk(nm, exp, bad);
  endtask : stay
  task automatic blink(input string nm, input logic [31:0] on);
    wait_sig(nm, 32'h0, 45);
    wait_sig(nm, on, 45);
    wait_sig(nm, 32'h0, 45);
  endtask : blink
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic mode_is(input logic [6:0] m);
    apb(1'b0, gamc_pkg::OFF_STATUS, 32'h0);
    chk("mode", 32'(m), 32'(d[13:7]));
  endtask : mode_is
  task automatic hold(input int k, input int n);
    @(posedge pclk);
    cmd_keys[k] <= 1'b1;
    repeat (n) @(posedge pclk);
    cmd_keys[k] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : hold
  task automatic set_conc(input logic [15:0] v);
    @(posedge pclk);
    cmd_conc <= v;
  endtask : set_conc
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // ==========================================================
  // tests
  initial begin
    #60000;
    errors++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cmd_conc, cmd_keys, cmd_present, cmd_fault} = {22'h0, 2'h3};
    {errors, n_checks} = '0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    stay("sel", 32'(gamc_pkg::DSP_BANNER), 1);
    @(posedge pclk);
    presetn <= 1'b1;
    wait_sig("sel", 32'(gamc_pkg::DSP_VERSION), 40);
    chk("version", 32'(VERSION_ID), 32'(value));
    wait_sig("sel", 32'(gamc_pkg::DSP_WARM), 40);
    chk("version span", 32'h1, 32'(waited >= 18 && waited <= 22));
    wait_sig("sel", 32'(gamc_pkg::DSP_CONC), 1300);
    chk("warm span", 32'h1, 32'(waited >= 1195 && waited <= 1205));
    mode_is(gamc_pkg::GAMC_MEAS);
    chk("fault alarm", 32'h1, 32'(d[5]));
    cmd_fault <= 1'b0;
    hold(3, 2);
    mode_is(gamc_pkg::GAMC_MEAS);
    chk("fault clear", 32'h0, 32'(d[5]));
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reg reset", rv[i], d);
    end
    chk("slverr", 32'h1, 32'(e));
    apb(1'b1, gamc_pkg::OFF_DWELL, 32'h3FFFF);
    apb(1'b0, gamc_pkg::OFF_DWELL, 32'h0);
    chk("dwell", 32'h3FFFF, d);
    $display("test startup done");
    foreach (cv[i]) begin
      set_conc(cv[i]);
      repeat (4) @(negedge pclk);
      stay("sel", 32'(cs[i]), 10);
    end
    @(posedge pclk);
    cmd_present <= 1'b0;
    wait_sig("sel", 32'(gamc_pkg::DSP_UNDER), 10);
    wait_sig("trbl", 32'h1, 5);
    wait_sig("trelay", 32'h1, 5);
    wait_sig("buzz", 32'h1, 5);
    blink("warn", 32'h1);
    blink("flash", 32'h1);
    hold(4, 2);
    wait_sig("buzz", 32'h0, 5);
    stay("warn", 32'h1, 50);
    @(posedge pclk);
    cmd_present <= 1'b1;
    wait_sig("sel", 32'(gamc_pkg::DSP_CONC), 10);
    set_conc(16'h006F);
    wait_sig("sel", 32'(gamc_pkg::DSP_OVER), 10);
    wait_sig("buzz", 32'h1, 5);
    blink("lamps", 32'h7);
    blink("warn", 32'h1);
    hold(4, 2);
    wait_sig("buzz", 32'h0, 5);
    set_conc(16'h0000);
    hold(3, 2);
    $display("test ranges done");
    apb(1'b1, gamc_pkg::OFF_DWELL, 32'h2082);
    set_conc(16'h0019);
    stay("relay", 32'h0, 80);
    wait_sig("relay", 32'h1, 100);
    mode_is(gamc_pkg::GAMC_MEAS);
    chk("alarms", 32'h1, 32'(d[2:0]));
    set_conc(16'h0000);
    stay("relay", 32'h1, 60);
    chk("peak", 32'h19, 32'(value));
    hold(5, 2);
    wait_sig("relay", 32'h0, 10);
    apb(1'b1, gamc_pkg::OFF_CTRL, 32'h0);
    set_conc(16'h002D);
    wait_sig("relay", 32'h3, 150);
    set_conc(16'h001E);
    wait_sig("relay", 32'h1, 10);
    set_conc(16'h0000);
    wait_sig("relay", 32'h0, 10);
    $display("test alarms done");
    hold(0, 4);
    mode_is(gamc_pkg::GAMC_MEAS);
    hold(0, 10);
    mode_is(gamc_pkg::GAMC_TEST);
    blink("flash", 32'h1);
    apb(1'b1, gamc_pkg::OFF_TESTVAL, 32'h3C);
    wait_sig("relay", 32'h7, 150);
    chk("test value", 32'h3C, 32'(value));
    hold(1, 10);
    mode_is(gamc_pkg::GAMC_LAMP);
    wait_sig("sel", 32'(gamc_pkg::DSP_LAMP), 5);
    hold(3, 2);
    mode_is(gamc_pkg::GAMC_MEAS);
    wait_sig("relay", 32'h0, 10);
    $display("test test_mode done");
    hold(2, 10);
    mode_is(gamc_pkg::GAMC_SBY);
    blink("sby", 32'h1);
    @(posedge pclk);
    cmd_present <= 1'b0;
    stay("trelay", 32'h0, 20);
    @(posedge pclk);
    cmd_present <= 1'b1;
    set_conc(16'h003C);
    stay("relay", 32'h0, 150);
    stay("trelay", 32'h0, 1);
    mode_is(gamc_pkg::GAMC_SBY);
    chk("alarms", 32'h7, 32'(d[2:0]));
    hold(2, 10);
    mode_is(gamc_pkg::GAMC_MEAS);
    wait_sig("relay", 32'h7, 10);
    $display("test standby done");
    close_out();
  end
endmodule : gas_alarm_mode_controller_bench
